// ### rtl/swk_pkg.sv
package swk_pkg;

   // axi4-lite register byte offsets
   localparam logic [7:0] ADDR_CORE_INT_CTRL = 8'h00;
   localparam logic [7:0] ADDR_PERIPH_EN     = 8'h04;
   localparam logic [7:0] ADDR_PERIPH_FLAGS  = 8'h08;
   localparam logic [7:0] ADDR_PIN_CHG_EN    = 8'h0C;
   localparam logic [7:0] ADDR_PWR_STATUS    = 8'h10;
   localparam logic [7:0] ADDR_CORE_CMD      = 8'h14;
   localparam logic [7:0] ADDR_IRQ_STATUS    = 8'h18;
   localparam logic [7:0] ADDR_IRQ_MASK      = 8'h1C;
   localparam logic [7:0] ADDR_OSC_MODE      = 8'h20;

   // core interrupt control fields
   localparam int GLB_EN_BIT   = 7;
   localparam int PER_EN_BIT   = 6;
   localparam int TIM_EN_BIT   = 5;
   localparam int EXT_EN_BIT   = 4;
   localparam int PIN_EN_BIT   = 3;
   localparam int TIM_FLAG_BIT = 2;
   localparam int EXT_FLAG_BIT = 1;
   localparam int PIN_FLAG_BIT = 0;

   // power status fields
   localparam int TIMEOUT_BIT  = 1;
   localparam int PWRDN_BIT    = 0;

   // command register fields
   localparam int CMD_SLEEP_BIT  = 0;
   localparam int CMD_WDCLR_BIT  = 1;

   // irq status fields
   localparam int EV_SKIP_BIT  = 0;
   localparam int EV_SLEEP_BIT = 1;
   localparam int EV_WAKE_BIT  = 2;
   localparam int EV_VEC_BIT   = 3;

   // reset values
   localparam logic [7:0] CORE_INT_CTRL_RST = 8'h00;
   localparam logic [7:0] PERIPH_RST        = 8'h00;
   localparam logic [1:0] PWR_STATUS_RST    = 2'h3;
   localparam logic [3:0] IRQ_RST           = 4'h0;
   localparam logic [1:0] OSC_MODE_RST      = 2'h0;
   localparam logic [1:0] OSC_EXTERNAL      = 2'h3;

   // dummy cycles before vectoring
   localparam int DUMMY_CYCLES = 2;
   localparam logic [15:0] VECTOR_ADDR = 16'h0004;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum {
      ST_RUN,
      ST_SLEEP_EXEC,
      ST_ASLEEP,
      ST_WAKE_NEXT,
      ST_DUMMY,
      ST_VECTOR
   } swk_state_type;

   // register bus write request
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] data;
      logic [3:0]  strb;
   } swk_wreq_type;

   // core sequencing outputs
   typedef struct packed {
      logic        clock_gate;
      logic        wd_clear;
      logic        vector_take;
      logic        fetch_next;
   } swk_core_type;

endpackage

// ### rtl/swk_wake_detect.sv
`timescale 1ns/1ps
module swk_wake_detect
   import swk_pkg::*;
(
   input  wire logic       CLK_SYS,
   input  wire logic       RESET,
   input  wire logic       CE,
   input  wire logic [7:0] CORE_CTRL,
   input  wire logic [7:0] PERIPH_EN,
   input  wire logic [7:0] PERIPH_FLAGS,
   input  wire logic       PERIPH_OK,
   output logic            WAKE
);

   logic core_hit;
   logic periph_hit;

   // enable-and-flag pairs, independent of the global enable
   always_comb begin
      core_hit = (CORE_CTRL[TIM_EN_BIT] & CORE_CTRL[TIM_FLAG_BIT])
               | (CORE_CTRL[EXT_EN_BIT] & CORE_CTRL[EXT_FLAG_BIT])
               | (CORE_CTRL[PIN_EN_BIT] & CORE_CTRL[PIN_FLAG_BIT]);
      periph_hit = PERIPH_OK & (|(PERIPH_EN & PERIPH_FLAGS));
   end

   // registered wake level
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         WAKE <= 1'b0;
      end else if (CE) begin
         WAKE <= core_hit | periph_hit;
      end
   end

endmodule

// ### rtl/swk_pin_sync.sv
`timescale 1ns/1ps
module swk_pin_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             CLK_SYS,
   input  wire logic             RESET,
   input  wire logic             CE,
   input  wire logic [WIDTH-1:0] D,
   output logic      [WIDTH-1:0] Q
);

   logic [WIDTH-1:0] stage1;

   // two-flop synchroniser for pin-side levels
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         stage1 <= '0;
         Q      <= '0;
      end else if (CE) begin
         stage1 <= D;
         Q      <= stage1;
      end
   end

endmodule

// ### rtl/swk_sleep_ctrl.sv
`timescale 1ns/1ps
module swk_sleep_ctrl
   import swk_pkg::*;
#(
   parameter int PIN_WIDTH = 4
) (
   input  wire logic                 CLK_SYS,
   input  wire logic                 RESET,
   input  wire logic                 CE,
   // axi4-lite slave
   input  wire logic [7:0]           S_AXI_AWADDR,
   input  wire logic                 S_AXI_AWVALID,
   output logic                      S_AXI_AWREADY,
   input  wire logic [31:0]          S_AXI_WDATA,
   input  wire logic [3:0]           S_AXI_WSTRB,
   input  wire logic                 S_AXI_WVALID,
   output logic                      S_AXI_WREADY,
   output logic [1:0]                S_AXI_BRESP,
   output logic                      S_AXI_BVALID,
   input  wire logic                 S_AXI_BREADY,
   input  wire logic [7:0]           S_AXI_ARADDR,
   input  wire logic                 S_AXI_ARVALID,
   output logic                      S_AXI_ARREADY,
   output logic [31:0]               S_AXI_RDATA,
   output logic [1:0]                S_AXI_RRESP,
   output logic                      S_AXI_RVALID,
   input  wire logic                 S_AXI_RREADY,
   // interrupt sources from peripherals and pins
   input  wire logic [7:0]           PERIPH_FLAG_SET,
   input  wire logic [PIN_WIDTH-1:0] PIN_CHANGE,
   input  wire logic                 EXT_INT_PIN,
   input  wire logic                 TIMER0_OVF,
   // core side
   input  wire logic                 SLEEP_EXEC,
   input  wire logic                 WD_CLEAR_EXEC,
   input  wire logic                 INSTR_CLK,
   output logic                      CORE_CLK_GATE,
   output logic                      WD_CLEAR,
   output logic                      VECTOR_TAKE,
   output logic [15:0]               VECTOR_PC,
   output logic                      CLOCK_OUT,
   output logic                      CLOCK_OUT_OE,
   output logic                      IRQ
);

   initial begin
      if (PIN_WIDTH < 1 || PIN_WIDTH > 8) begin
         $error("PIN_WIDTH must be 1 to 8");
      end
   end

   logic [7:0]           core_ctrl;
   logic [7:0]           periph_en;
   logic [7:0]           periph_flags;
   logic [7:0]           pin_chg_en;
   logic [1:0]           pwr_status;
   logic [3:0]           irq_status;
   logic [3:0]           irq_mask;
   logic [1:0]           osc_mode;
   logic                 wake;
   logic [PIN_WIDTH-1:0] pin_sync;
   logic [PIN_WIDTH-1:0] pin_last;
   logic [1:0]           misc_sync;
   logic [1:0]           misc_last;
   logic                 pin_event;
   logic                 int_edge;
   swk_state_type        state;
   logic [1:0]           dummy_cnt;
   logic [3:0]           ev;
   swk_core_type         core;

   // axi channel state
   logic                 aw_held;
   logic                 w_held;
   swk_wreq_type         wreq;
   logic                 wr_fire;
   logic                 rd_fire;
   logic [7:0]           rd_addr;
   logic                 cmd_sleep;
   logic                 cmd_wdclr;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   swk_pin_sync #(
      .WIDTH (PIN_WIDTH)
   ) u_pin_sync (
      .CLK_SYS (CLK_SYS),
      .RESET   (RESET),
      .CE      (CE),
      .D       (PIN_CHANGE),
      .Q       (pin_sync)
   );

   swk_pin_sync #(
      .WIDTH (2)
   ) u_misc_sync (
      .CLK_SYS (CLK_SYS),
      .RESET   (RESET),
      .CE      (CE),
      .D       ({EXT_INT_PIN, INSTR_CLK}),
      .Q       (misc_sync)
   );

   // edge history after synchronisation
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         pin_last  <= '0;
         misc_last <= 2'h0;
      end else if (CE) begin
         pin_last  <= pin_sync;
         misc_last <= misc_sync;
      end
   end

   assign pin_event = |((pin_sync ^ pin_last) & pin_chg_en[7 -: PIN_WIDTH]);
   assign int_edge  = misc_sync[1] & ~misc_last[1];

   ////////////////////////////////////////////////////////////////////////////
   // wake condition

   swk_wake_detect u_wake (
      .CLK_SYS      (CLK_SYS),
      .RESET        (RESET),
      .CE           (CE),
      .CORE_CTRL    (core_ctrl),
      .PERIPH_EN    (periph_en),
      .PERIPH_FLAGS (periph_flags),
      .PERIPH_OK    (core_ctrl[PER_EN_BIT]),
      .WAKE         (wake)
   );

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite write path

   assign S_AXI_AWREADY = ~aw_held & ~S_AXI_BVALID;
   assign S_AXI_WREADY  = ~w_held & ~S_AXI_BVALID;
   assign wr_fire       = aw_held & w_held & ~S_AXI_BVALID;

   // capture address and data in either order
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         wreq    <= '0;
      end else if (CE) begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_held   <= 1'b1;
            wreq.addr <= S_AXI_AWADDR;
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_held    <= 1'b1;
            wreq.data <= S_AXI_WDATA;
            wreq.strb <= S_AXI_WSTRB;
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end
      end
   end

   // write response
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP  <= RESP_OKAY;
      end else if (CE) begin
         if (wr_fire) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= (wreq.addr > ADDR_OSC_MODE || wreq.addr[1:0] != 2'h0)
                            ? RESP_SLVERR : RESP_OKAY;
         end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
      end
   end

   assign cmd_sleep = (wr_fire && wreq.addr == ADDR_CORE_CMD && wreq.strb[0]
                       && wreq.data[CMD_SLEEP_BIT]) || SLEEP_EXEC;
   assign cmd_wdclr = (wr_fire && wreq.addr == ADDR_CORE_CMD && wreq.strb[0]
                       && wreq.data[CMD_WDCLR_BIT]) || WD_CLEAR_EXEC;

   ////////////////////////////////////////////////////////////////////////////
   // control registers

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         core_ctrl  <= CORE_INT_CTRL_RST;
         periph_en  <= PERIPH_RST;
         pin_chg_en <= PERIPH_RST;
         irq_mask   <= IRQ_RST;
         osc_mode   <= OSC_MODE_RST;
      end else if (CE) begin
         if (wr_fire && wreq.strb[0]) begin
            case (wreq.addr)
               ADDR_CORE_INT_CTRL: core_ctrl[7:3] <= wreq.data[7:3];
               ADDR_PERIPH_EN:     periph_en      <= wreq.data[7:0];
               ADDR_PIN_CHG_EN:    pin_chg_en     <= {wreq.data[7:4], 4'h0};
               ADDR_IRQ_MASK:      irq_mask       <= wreq.data[3:0];
               ADDR_OSC_MODE:      osc_mode       <= wreq.data[1:0];
               default: ;
            endcase
         end
         // hardware sets win over software clears
         if (wr_fire && wreq.strb[0] && wreq.addr == ADDR_CORE_INT_CTRL) begin
            core_ctrl[2:0] <= wreq.data[2:0];
         end
         if (TIMER0_OVF) begin
            core_ctrl[TIM_FLAG_BIT] <= 1'b1;
         end
         if (int_edge) begin
            core_ctrl[EXT_FLAG_BIT] <= 1'b1;
         end
         if (pin_event) begin
            core_ctrl[PIN_FLAG_BIT] <= 1'b1;
         end
      end
   end

   // peripheral flags: set by hardware at any time, set wins
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         periph_flags <= PERIPH_RST;
      end else if (CE) begin
         if (wr_fire && wreq.strb[0] && wreq.addr == ADDR_PERIPH_FLAGS) begin
            periph_flags <= wreq.data[7:0] | PERIPH_FLAG_SET;
         end else begin
            periph_flags <= periph_flags | PERIPH_FLAG_SET;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sleep sequencer

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         state     <= ST_RUN;
         dummy_cnt <= 2'h0;
      end else if (CE) begin
         case (state)
            ST_RUN: begin
               if (cmd_sleep && !wake) begin
                  state <= ST_SLEEP_EXEC;
               end
            end
            ST_SLEEP_EXEC: begin
               // instruction completes before any wake
               state <= wake ? ST_WAKE_NEXT : ST_ASLEEP;
            end
            ST_ASLEEP: begin
               if (wake) begin
                  state <= ST_WAKE_NEXT;
               end
            end
            ST_WAKE_NEXT: begin
               dummy_cnt <= 2'(DUMMY_CYCLES);
               state     <= core_ctrl[GLB_EN_BIT] ? ST_DUMMY : ST_RUN;
            end
            ST_DUMMY: begin
               dummy_cnt <= dummy_cnt - 2'h1;
               if (dummy_cnt == 2'h1) begin
                  state <= ST_VECTOR;
               end
            end
            ST_VECTOR: state <= ST_RUN;
            default:   state <= ST_RUN;
         endcase
      end
   end

   // core strobes
   always_comb begin
      core.clock_gate  = (state == ST_ASLEEP);
      core.wd_clear    = (state == ST_RUN && cmd_sleep && !wake) || cmd_wdclr;
      core.vector_take = (state == ST_VECTOR);
      core.fetch_next  = (state == ST_WAKE_NEXT);
   end

   assign CORE_CLK_GATE = core.clock_gate;
   assign WD_CLEAR      = core.wd_clear;
   assign VECTOR_TAKE   = core.vector_take;
   assign VECTOR_PC     = VECTOR_ADDR;

   // timeout and power-down flags
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         pwr_status <= PWR_STATUS_RST;
      end else if (CE) begin
         if (state == ST_RUN && cmd_sleep && !wake) begin
            pwr_status[TIMEOUT_BIT] <= 1'b1;
            pwr_status[PWRDN_BIT]   <= 1'b0;
         end else if (cmd_wdclr) begin
            pwr_status <= PWR_STATUS_RST;
         end
         // sleep with wake pending leaves both flags alone
      end
   end

   // clock output, never driven in external clock mode
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         CLOCK_OUT    <= 1'b0;
         CLOCK_OUT_OE <= 1'b0;
      end else if (CE) begin
         CLOCK_OUT    <= misc_sync[0];
         CLOCK_OUT_OE <= (osc_mode != OSC_EXTERNAL) && !core.clock_gate;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt status, write one to clear, set wins

   always_comb begin
      ev = 4'h0;
      ev[EV_SKIP_BIT]  = (state == ST_RUN) && cmd_sleep && wake;
      ev[EV_SLEEP_BIT] = (state == ST_SLEEP_EXEC);
      ev[EV_WAKE_BIT]  = (state == ST_WAKE_NEXT);
      ev[EV_VEC_BIT]   = (state == ST_VECTOR);
   end

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         irq_status <= IRQ_RST;
      end else if (CE) begin
         if (wr_fire && wreq.strb[0] && wreq.addr == ADDR_IRQ_STATUS) begin
            irq_status <= (irq_status & ~wreq.data[3:0]) | ev;
         end else begin
            irq_status <= irq_status | ev;
         end
      end
   end

   assign IRQ = |(irq_status & irq_mask);

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite read path

   assign S_AXI_ARREADY = ~S_AXI_RVALID;
   assign rd_fire       = S_AXI_ARVALID & S_AXI_ARREADY;
   assign rd_addr       = S_AXI_ARADDR;

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA  <= 32'h0000_0000;
         S_AXI_RRESP  <= RESP_OKAY;
      end else if (CE) begin
         if (rd_fire) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP  <= RESP_OKAY;
            case (rd_addr)
               ADDR_CORE_INT_CTRL: S_AXI_RDATA <= {24'h0, core_ctrl};
               ADDR_PERIPH_EN:     S_AXI_RDATA <= {24'h0, periph_en};
               ADDR_PERIPH_FLAGS:  S_AXI_RDATA <= {24'h0, periph_flags};
               ADDR_PIN_CHG_EN:    S_AXI_RDATA <= {24'h0, pin_chg_en};
               ADDR_PWR_STATUS:    S_AXI_RDATA <= {30'h0, pwr_status};
               ADDR_CORE_CMD:      S_AXI_RDATA <= {29'h0, wake, core.clock_gate, 1'b0};
               ADDR_IRQ_STATUS:    S_AXI_RDATA <= {28'h0, irq_status};
               ADDR_IRQ_MASK:      S_AXI_RDATA <= {28'h0, irq_mask};
               ADDR_OSC_MODE:      S_AXI_RDATA <= {30'h0, osc_mode};
               default: begin
                  S_AXI_RDATA <= 32'h0000_0000;
                  S_AXI_RRESP <= RESP_SLVERR;
               end
            endcase
         end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
         end
      end
   end

endmodule

// ### tb/swk_sleep_ctrl_sva.sv
`timescale 1ns/1ps
module swk_checker
   import swk_pkg::*;
(
   input wire logic        CLK_SYS,
   input wire logic        RESET,
   input wire logic        S_AXI_AWVALID,
   input wire logic        S_AXI_AWREADY,
   input wire logic        S_AXI_WVALID,
   input wire logic        S_AXI_WREADY,
   input wire logic [1:0]  S_AXI_BRESP,
   input wire logic        S_AXI_BVALID,
   input wire logic        S_AXI_BREADY,
   input wire logic        S_AXI_ARVALID,
   input wire logic        S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic        S_AXI_RVALID,
   input wire logic        S_AXI_RREADY,
   input wire logic        SLEEP_EXEC,
   input wire logic        WD_CLEAR_EXEC,
   input wire logic        CORE_CLK_GATE,
   input wire logic        WD_CLEAR,
   input wire logic        VECTOR_TAKE,
   input wire logic [15:0] VECTOR_PC,
   input wire logic        CLOCK_OUT_OE
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RESET);

   // both write channels taken at one edge
   sequence s_wr_both;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   endsequence
   // sleep requested while a wake is already pending
   sequence s_no_op;
      SLEEP_EXEC && !WD_CLEAR && !CORE_CLK_GATE;
   endsequence

   ////////////////////////////////////////////////////////////
   a_wr_latency: assert property (s_wr_both |-> ##2 S_AXI_BVALID)
      else $error("write response late");
   a_rd_latency: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read data late");
   a_ar_block: assert property (S_AXI_ARREADY != S_AXI_RVALID)
      else $error("read address ready wrong");
   a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY
                              |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data dropped");
   a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY
                              |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response dropped");
   a_aw_busy: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
      else $error("address taken during response");
   a_no_op_gate: assert property (s_no_op |=> !CORE_CLK_GATE[*3])
      else $error("no-op sleep gated the clock");
   a_sleep_clears: assert property ($rose(CORE_CLK_GATE) |-> $past(WD_CLEAR, 2))
      else $error("sleep entered without watchdog clear");
   a_wdclr_cause: assert property (WD_CLEAR && !SLEEP_EXEC && !WD_CLEAR_EXEC |=> S_AXI_BVALID)
      else $error("watchdog clear without cause");
   a_vec_dummy: assert property ($fell(CORE_CLK_GATE) |-> !VECTOR_TAKE[*3])
      else $error("vector before dummy cycles");
   a_vec_pulse: assert property (VECTOR_TAKE |=> !VECTOR_TAKE)
      else $error("vector pulse too long");
   a_vec_addr: assert property (VECTOR_TAKE |-> VECTOR_PC == VECTOR_ADDR)
      else $error("vector address wrong");
   a_oe_asleep: assert property (CORE_CLK_GATE[*2] |-> !CLOCK_OUT_OE)
      else $error("clock output driven while asleep");
endmodule

bind swk_sleep_ctrl swk_checker u_chk (.CLK_SYS, .RESET, .S_AXI_AWVALID, .S_AXI_AWREADY,
   .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID,
   .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY, .SLEEP_EXEC, .WD_CLEAR_EXEC,
   .CORE_CLK_GATE, .WD_CLEAR, .VECTOR_TAKE, .VECTOR_PC, .CLOCK_OUT_OE);

// ### tb/tb_swk_sleep_ctrl.sv
`timescale 1ns/1ps
module tb_swk_sleep_ctrl
   import swk_pkg::*;
;
   logic        CLK_SYS, RESET, CE, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID;
   logic        S_AXI_RREADY, EXT_INT_PIN, TIMER0_OVF, SLEEP_EXEC, WD_CLEAR_EXEC, INSTR_CLK;
   logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
   logic        CORE_CLK_GATE, WD_CLEAR, VECTOR_TAKE, CLOCK_OUT, CLOCK_OUT_OE, IRQ;
   logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
   logic [2:0]  ih;
   logic [3:0]  S_AXI_WSTRB, PIN_CHANGE;
   logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR, PERIPH_FLAG_SET;
   logic [15:0] VECTOR_PC;
   logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
   logic [33:0] rq[$], bq[$];
   logic [7:0]  ra[5] = '{ADDR_CORE_INT_CTRL, ADDR_PERIPH_EN, ADDR_PWR_STATUS, ADDR_IRQ_MASK,
                          ADDR_OSC_MODE};
   logic [31:0] rv[5] = '{32'(CORE_INT_CTRL_RST), 32'(PERIPH_RST), 32'(PWR_STATUS_RST),
                          32'(IRQ_RST), 32'(OSC_MODE_RST)};
   integer      seed = 32'hC868;
   int          miscompares = 0;
   int          checks = 0;

   swk_sleep_ctrl DUT (.CLK_SYS, .RESET, .CE, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
      .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
      .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
      .S_AXI_RVALID, .S_AXI_RREADY, .PERIPH_FLAG_SET, .PIN_CHANGE, .EXT_INT_PIN, .TIMER0_OVF,
      .SLEEP_EXEC, .WD_CLEAR_EXEC, .INSTR_CLK, .CORE_CLK_GATE, .WD_CLEAR, .VECTOR_TAKE,
      .VECTOR_PC, .CLOCK_OUT, .CLOCK_OUT_OE, .IRQ);

   ////////////////////////////////////////////////////////////
   // clock and random instruction clock
   always #12.5 CLK_SYS = ~CLK_SYS;
   always @(posedge CLK_SYS) INSTR_CLK <= 1'($random(seed));
   // history of the instruction clock: two sync stages plus the output flop
   always @(posedge CLK_SYS) ih <= {ih[1:0], INSTR_CLK};

   task check(input logic [33:0] got, input logic [33:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task final_report;
      if (miscompares == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // bus answers compared against the oldest note
   always @(negedge CLK_SYS) begin
      if (S_AXI_RVALID && S_AXI_RREADY) check({S_AXI_RDATA, S_AXI_RRESP}, rq.pop_front());
      if (S_AXI_BVALID && S_AXI_BREADY) check({32'h0, S_AXI_BRESP}, bq.pop_front());
   end

   // hang guard
   initial begin
      #500000;
      miscompares++;
      final_report;
   end

   ////////////////////////////////////////////////////////////
   task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic aw, w, b;
      bq.push_back({32'h0, r});
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_BREADY <= 1'b1;
      b = 1'b0;
      while (!b) begin
         @(negedge CLK_SYS);
         aw = S_AXI_AWVALID && S_AXI_AWREADY;
         w = S_AXI_WVALID && S_AXI_WREADY;
         b = S_AXI_BVALID;
         @(posedge CLK_SYS);
         if (aw) S_AXI_AWVALID <= 1'b0;
         if (w) S_AXI_WVALID <= 1'b0;
      end
      S_AXI_BREADY <= 1'b0;
      @(posedge CLK_SYS);
   endtask

   task axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic ar, v;
      rq.push_back({d, r});
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY <= 1'b1;
      v = 1'b0;
      while (!v) begin
         @(negedge CLK_SYS);
         ar = S_AXI_ARVALID && S_AXI_ARREADY;
         v = S_AXI_RVALID;
         @(posedge CLK_SYS);
         if (ar) S_AXI_ARVALID <= 1'b0;
      end
      S_AXI_RREADY <= 1'b0;
      @(posedge CLK_SYS);
   endtask

   // one event from source k: peripheral, timer, external pin, pin change
   task fire(input int k);
      case (k)
         0: PERIPH_FLAG_SET <= 8'($random(seed)) | 8'h01;
         1: TIMER0_OVF <= 1'b1;
         2: EXT_INT_PIN <= 1'b1;
         default: PIN_CHANGE <= 4'h1;
      endcase
      @(posedge CLK_SYS);
      PERIPH_FLAG_SET <= 8'h00;
      TIMER0_OVF <= 1'b0;
   endtask

   // sleep pulse, then watchdog clear and gating compared with expectation
   task sleep(input logic e);
      SLEEP_EXEC <= 1'b1;
      @(negedge CLK_SYS);
      check(34'(WD_CLEAR), 34'(e));
      @(posedge CLK_SYS);
      SLEEP_EXEC <= 1'b0;
      repeat (4) @(posedge CLK_SYS);
      @(negedge CLK_SYS);
      check(34'(CORE_CLK_GATE), 34'(e));
      @(posedge CLK_SYS);
   endtask

   task sleep_wake(input int k, input logic global_interrupt_enable);
      int n;
      axi_wr(ADDR_CORE_INT_CTRL, {24'h0, global_interrupt_enable, 7'h78}, RESP_OKAY);
      axi_wr(ADDR_PERIPH_FLAGS, 32'h0, RESP_OKAY);
      axi_wr(ADDR_IRQ_STATUS, 32'hF, RESP_OKAY);
      sleep(1'b1);
      axi_rd(ADDR_PWR_STATUS, 32'h2, RESP_OKAY);
      fire(k);
      n = 0;
      do begin
         @(negedge CLK_SYS);
         n++;
      end while (CORE_CLK_GATE !== 1'b0 && n < 20);
      check(34'(CORE_CLK_GATE), 34'(0));
      n = 0;
      while (VECTOR_TAKE !== 1'b1 && n < 8) begin
         @(negedge CLK_SYS);
         n++;
      end
      check(34'(n), global_interrupt_enable ? 34'(3) : 34'(8));
      @(posedge CLK_SYS);
      axi_rd(ADDR_IRQ_STATUS, {28'h0, global_interrupt_enable, 3'h6}, RESP_OKAY);
   endtask

   ////////////////////////////////////////////////////////////
   initial begin
      CLK_SYS = 1'b0;
      RESET = 1'b1;
      CE = 1'b1;
      {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h00;
      {EXT_INT_PIN, TIMER0_OVF, SLEEP_EXEC, WD_CLEAR_EXEC} = 4'h0;
      {S_AXI_AWADDR, S_AXI_ARADDR, PERIPH_FLAG_SET, PIN_CHANGE} = 28'h0;
      S_AXI_WSTRB = 4'hF;
      S_AXI_WDATA = 32'h0;
      repeat (20) @(posedge CLK_SYS);
      RESET <= 1'b0;
      @(posedge CLK_SYS);
      // reset values, read-only status, unmapped place
      foreach (ra[i]) axi_rd(ra[i], rv[i], RESP_OKAY);
      axi_rd(8'h24, 32'h0, RESP_SLVERR);
      axi_wr(8'h24, 32'hFF, RESP_SLVERR);
      axi_wr(ADDR_PWR_STATUS, 32'h0, RESP_OKAY);
      axi_rd(ADDR_PWR_STATUS, 32'h3, RESP_OKAY);
      // clock output per oscillator mode
      for (int m = 0; m < 5; m++) begin
         axi_wr(ADDR_OSC_MODE, 32'(m % 4), RESP_OKAY);
         repeat (2) @(posedge CLK_SYS);
         @(negedge CLK_SYS);
         check(34'(CLOCK_OUT_OE), 34'((m % 4) != 3));
         check(34'(CLOCK_OUT), 34'(ih[2]));
         @(posedge CLK_SYS);
      end
      // no-op sleep: flag rises after software saw it clear
      axi_wr(ADDR_PIN_CHG_EN, 32'h10, RESP_OKAY);
      axi_wr(ADDR_PERIPH_EN, 32'h01, RESP_OKAY);
      axi_wr(ADDR_CORE_INT_CTRL, 32'h40, RESP_OKAY);
      axi_rd(ADDR_PERIPH_FLAGS, 32'h0, RESP_OKAY);
      fire(0);
      repeat (2) @(posedge CLK_SYS);
      sleep(1'b0);
      axi_rd(ADDR_PWR_STATUS, 32'h3, RESP_OKAY);
      axi_rd(ADDR_IRQ_STATUS, 32'h1, RESP_OKAY);
      check(34'(IRQ), 34'(0));
      axi_wr(ADDR_IRQ_MASK, 32'hF, RESP_OKAY);
      check(34'(IRQ), 34'(1));
      axi_wr(ADDR_IRQ_STATUS, 32'h1, RESP_OKAY);
      check(34'(IRQ), 34'(0));
      // watchdog clear just before sleeping
      WD_CLEAR_EXEC <= 1'b1;
      @(negedge CLK_SYS);
      check(34'(WD_CLEAR), 34'(1));
      @(posedge CLK_SYS);
      WD_CLEAR_EXEC <= 1'b0;
      @(posedge CLK_SYS);
      // real sleep and wake from each source, global enable alternating
      for (int k = 0; k < 4; k++) sleep_wake(k, k[0]);
      // bus command: sleep with wake pending skips, watchdog clear restores flags
      axi_wr(ADDR_CORE_CMD, 32'h3, RESP_OKAY);
      axi_rd(ADDR_PWR_STATUS, 32'h3, RESP_OKAY);
      axi_rd(ADDR_IRQ_STATUS, 32'hF, RESP_OKAY);
      final_report;
   end
endmodule
